// ===== core/mpio_filter.sv
module mpio_filter #(
	parameter int HOLD = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic tick,
	input wire logic raw,
	output logic clean
);
	logic [1:0] sync;
	logic [3:0] cnt;

	initial
	begin
		if (HOLD < 1 || HOLD > 15)
			$error("mpio_filter HOLD out of range");
	end

	// Two-stage synchroniser
	always_ff @(posedge clk)
	begin
		if (reset)
			sync <= 2'h0;
		else if (ce)
			sync <= {sync[0], raw};
	end

	// Accept a level only after it holds for HOLD+1 instruction ticks
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt <= 4'h0;
			clean <= 1'b0;
		end
		else if (ce)
		begin
			if (sync[1] == clean)
				cnt <= 4'h0;
			else if (tick)
			begin
				// Extra tick covers phase so short pulses never pass
				if (cnt == 4'(HOLD))
				begin
					clean <= sync[1];
					cnt <= 4'h0;
				end
				else
					cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

// ===== core/mpio_port.sv
// Operation
// - After clear falls, wait release delay, then fetch from address zero.
// - Analog read copies the four key inputs into the accumulator.
// - Misc read packs low, timer, wake, irq inputs into accumulator bits 0-3.
// - Wake and irq inputs reject pulses under two instruction cycles.
// - Sixteen bank pins each have an individually set or reset latch.
// - Bit test samples the bank pin picked by the word pick field.
// - After clear, bidirectional bank and pulldown pins come up as inputs.
// - Tristate write loads accumulator into the latch driving the pins.
// - Tristate read samples the pins and leaves them high impedance.
// - Pulldown write loads accumulator into the pulldown latch.
// - Pulldown read samples the pulldown pins into the accumulator.
// - Wide bank write targets the group chosen by the word pick field.
// - Pair ops move eight bits between groups 0,1 and accumulator/temp.
// - Tone pin is sound output or program-controlled general bit.
// - Clock mirror pin follows the internal system clock.
// - After power-on the system clock is reference divided by eight.
// - Ram pointer is a file pick field and a word pick field.
module mpio_port #(
	parameter int HOLD_INSTR = mpio_pkg::CLEAR_HOLD_INSTR,
	parameter int RELEASE_INSTR = mpio_pkg::CLEAR_RELEASE_INSTR
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic clear_in_pin,
	input wire logic [3:0] op,
	input wire logic op_valid,
	input wire logic [3:0] acc_in,
	input wire logic [3:0] temp_nibble_in,
	input wire logic [3:0] file_pick_field,
	input wire logic [3:0] word_pick_field,
	input wire logic tone_src,
	input wire logic [3:0] analog_key_in,
	input wire logic buffered_low_in,
	input wire logic timer_clock_in,
	input wire logic debounced_wake_in,
	input wire logic debounced_irq_in,
	input wire logic [3:0] tristate_nibble_in,
	input wire logic [3:0] pulldown_nibble_one_in,
	input wire logic [15:0] select_line_bank_in,
	output logic [3:0] tristate_nibble_out,
	output logic [3:0] tristate_nibble_oe,
	output logic [3:0] pulldown_nibble_one_out,
	output logic [3:0] pulldown_nibble_one_oe,
	output logic [15:0] select_line_bank_out,
	output logic [15:0] select_line_bank_oe,
	output logic [15:0] wide_nibble_bank,
	output logic [3:0] acc_out,
	output logic [3:0] temp_nibble_out,
	output logic acc_load,
	output logic bank_test_flag,
	output logic tone_out,
	output logic sysclk_mirror,
	output logic [7:0] ram_pointer,
	output logic in_reset,
	output logic fetch_start,
	output logic [12:0] fetch_addr
);
	localparam int NI = mpio_pkg::NIB;

	logic [1:0] clr_sync;
	logic [15:0] bank_sync0;
	logic [15:0] bank_sync;
	logic [3:0] key_sync0, key_sync;
	logic [3:0] tri_sync0, tri_sync;
	logic [3:0] pd_sync0, pd_sync;
	logic [1:0] low_sync0, low_sync;
	logic wake_clean, irq_clean;
	logic slow_clk;
	logic tick;
	logic instr_tick;
	logic [7:0] instr_cnt;
	logic [7:0] instr_lim;
	logic [3:0] rel_cnt;
	logic releasing;
	logic tone_gp;
	logic tone_sel;
	logic [3:0] next_acc;
	logic next_load;
	logic is_op;

	initial
	begin
		if (HOLD_INSTR < 1 || HOLD_INSTR > 15 || RELEASE_INSTR < 1 || RELEASE_INSTR > 15)
			$error("mpio_port timing parameters out of range");
	end

	function automatic logic [3:0] grp(input logic [15:0] bank, input logic [3:0] sel);
		grp = bank[sel[1:0]*4 +: 4];
	endfunction

	assign is_op = op_valid && !in_reset;

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			clr_sync <= 2'h0;
			bank_sync0 <= 16'h0000;
			bank_sync <= 16'h0000;
			key_sync0 <= 4'h0;
			key_sync <= 4'h0;
			tri_sync0 <= 4'h0;
			tri_sync <= 4'h0;
			pd_sync0 <= 4'h0;
			pd_sync <= 4'h0;
			low_sync0 <= 2'h0;
			low_sync <= 2'h0;
		end
		else if (ce)
		begin
			clr_sync <= {clr_sync[0], clear_in_pin};
			bank_sync0 <= select_line_bank_in;
			bank_sync <= bank_sync0;
			key_sync0 <= analog_key_in;
			key_sync <= key_sync0;
			tri_sync0 <= tristate_nibble_in;
			tri_sync <= tri_sync0;
			pd_sync0 <= pulldown_nibble_one_in;
			pd_sync <= pd_sync0;
			low_sync0 <= {timer_clock_in, buffered_low_in};
			low_sync <= low_sync0;
		end
	end

	mpio_filter #(.HOLD(mpio_pkg::FILTER_INSTR)) u_wake (
		.clk(clk), .reset(reset), .ce(ce), .tick(instr_tick),
		.raw(debounced_wake_in), .clean(wake_clean));
	mpio_filter #(.HOLD(mpio_pkg::FILTER_INSTR)) u_irq (
		.clk(clk), .reset(reset), .ce(ce), .tick(instr_tick),
		.raw(debounced_irq_in), .clean(irq_clean));

	////////////////////////////////////////////////////////////////
	// System clock divider and instruction tick
	assign instr_lim = slow_clk ? 8'(mpio_pkg::INSTR_CYCLES * mpio_pkg::SLOW_DIV / 2 - 1)
		: 8'(mpio_pkg::INSTR_CYCLES * mpio_pkg::FAST_DIV / 2 - 1);
	// Compare by bound so a speed change never strands the counter
	assign tick = (instr_cnt >= instr_lim);
	// One pulse per full instruction cycle
	assign instr_tick = tick && sysclk_mirror;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			instr_cnt <= 8'h00;
			sysclk_mirror <= 1'b0;
		end
		else if (ce)
		begin
			instr_cnt <= tick ? 8'h00 : instr_cnt + 8'h01;
			if (tick)
				sysclk_mirror <= ~sysclk_mirror;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset || clr_sync[1])
			slow_clk <= 1'b1;
		else if (ce && is_op && op == mpio_pkg::OP_CLK_SPEED)
			slow_clk <= acc_in[0];
	end

	////////////////////////////////////////////////////////////////
	// Clear sequencing
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			in_reset <= 1'b1;
			releasing <= 1'b0;
			rel_cnt <= 4'h0;
			fetch_start <= 1'b0;
			fetch_addr <= mpio_pkg::START_ADDR;
		end
		else if (ce)
		begin
			fetch_start <= 1'b0;
			if (clr_sync[1])
			begin
				in_reset <= 1'b1;
				releasing <= 1'b0;
				rel_cnt <= 4'h0;
			end
			else if (in_reset && !releasing)
				releasing <= 1'b1;
			else if (releasing && instr_tick)
			begin
				if (rel_cnt == 4'(RELEASE_INSTR - 1))
				begin
					releasing <= 1'b0;
					in_reset <= 1'b0;
					fetch_start <= 1'b1;
					fetch_addr <= mpio_pkg::START_ADDR;
				end
				else
					rel_cnt <= rel_cnt + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Output latches and directions
	always_ff @(posedge clk)
	begin
		if (reset || clr_sync[1])
		begin
			select_line_bank_out <= mpio_pkg::RESET_BANK;
			select_line_bank_oe <= 16'h03FF;
			pulldown_nibble_one_out <= mpio_pkg::RESET_NIB;
			pulldown_nibble_one_oe <= 4'h0;
			tristate_nibble_out <= mpio_pkg::RESET_NIB;
			tristate_nibble_oe <= 4'h0;
		end
		else if (ce && is_op)
		begin
			case (op)
				mpio_pkg::OP_BANK_SET:
					select_line_bank_out[word_pick_field] <= 1'b1;
				mpio_pkg::OP_BANK_RESET:
					select_line_bank_out[word_pick_field] <= 1'b0;
				mpio_pkg::OP_DIR:
				begin
					if (word_pick_field >= 4'(mpio_pkg::BIDIR_FIRST))
						select_line_bank_oe[word_pick_field] <= acc_in[0];
					else
						pulldown_nibble_one_oe <= acc_in;
				end
				mpio_pkg::OP_TRI_WRITE:
				begin
					tristate_nibble_out <= acc_in;
					tristate_nibble_oe <= 4'hF;
				end
				mpio_pkg::OP_TRI_READ:
					tristate_nibble_oe <= 4'h0;
				mpio_pkg::OP_PD_WRITE:
				begin
					pulldown_nibble_one_out <= acc_in;
					pulldown_nibble_one_oe <= 4'hF;
				end
				default:
					select_line_bank_out <= select_line_bank_out;
			endcase
		end
	end

	// Wide nibble bank and pair transfers
	always_ff @(posedge clk)
	begin
		if (reset || clr_sync[1])
			wide_nibble_bank <= mpio_pkg::RESET_BANK;
		else if (ce && is_op)
		begin
			if (op == mpio_pkg::OP_ACC_TO_WIDE)
				wide_nibble_bank[word_pick_field[1:0]*NI +: NI] <= acc_in;
			else if (op == mpio_pkg::OP_WIDE_STORE)
				wide_nibble_bank[7:0] <= {temp_nibble_in, acc_in};
		end
	end

	////////////////////////////////////////////////////////////////
	// Reads into the accumulator
	always_comb
	begin
		next_acc = acc_out;
		next_load = 1'b0;
		case (op)
			mpio_pkg::OP_READ_ANALOG:
			begin
				next_acc = key_sync;
				next_load = 1'b1;
			end
			mpio_pkg::OP_READ_MISC:
			begin
				next_acc = {irq_clean, wake_clean, low_sync[1], low_sync[0]};
				next_load = 1'b1;
			end
			mpio_pkg::OP_TRI_READ:
			begin
				next_acc = tri_sync;
				next_load = 1'b1;
			end
			mpio_pkg::OP_PD_READ:
			begin
				next_acc = pd_sync;
				next_load = 1'b1;
			end
			mpio_pkg::OP_WIDE_LOAD:
			begin
				next_acc = grp(wide_nibble_bank, 4'h0);
				next_load = 1'b1;
			end
			default:
				next_load = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			acc_out <= mpio_pkg::RESET_NIB;
			temp_nibble_out <= mpio_pkg::RESET_NIB;
			acc_load <= 1'b0;
			bank_test_flag <= 1'b0;
		end
		else if (ce)
		begin
			acc_load <= is_op && next_load;
			if (is_op && next_load)
				acc_out <= next_acc;
			if (is_op && op == mpio_pkg::OP_WIDE_LOAD)
				temp_nibble_out <= grp(wide_nibble_bank, 4'h1);
			if (is_op && op == mpio_pkg::OP_BANK_TEST)
				bank_test_flag <= bank_sync[word_pick_field];
		end
	end

	////////////////////////////////////////////////////////////////
	// Tone, pointer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tone_gp <= 1'b0;
			tone_sel <= 1'b0;
			tone_out <= 1'b0;
			ram_pointer <= 8'h00;
		end
		else if (ce)
		begin
			if (is_op && op == mpio_pkg::OP_TONE_GP)
			begin
				tone_sel <= acc_in[1];
				tone_gp <= acc_in[0];
			end
			tone_out <= tone_sel ? tone_gp : tone_src;
			ram_pointer <= {file_pick_field, word_pick_field};
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	AST_FETCH_ZERO: assert property (@(posedge clk) disable iff (reset)
		fetch_start |-> fetch_addr == 13'h0000 && !in_reset)
		else $error("fetch not at zero");
	AST_CLEAR_INPUT: assert property (@(posedge clk) disable iff (reset)
		ce && clr_sync[1] |=> select_line_bank_oe[15:10] == 6'h00 && pulldown_nibble_one_oe == 4'h0)
		else $error("pins not input after clear");
	AST_TRI_WRITE: assert property (@(posedge clk) disable iff (reset)
		ce && is_op && op == mpio_pkg::OP_TRI_WRITE && !clr_sync[1]
		|=> tristate_nibble_out == $past(acc_in) && tristate_nibble_oe == 4'hF)
		else $error("tristate write lost");
	AST_TRI_READ_HIZ: assert property (@(posedge clk) disable iff (reset)
		ce && is_op && op == mpio_pkg::OP_TRI_READ |=> tristate_nibble_oe == 4'h0)
		else $error("tristate read drives");
	AST_PD_READ: assert property (@(posedge clk) disable iff (reset)
		ce && is_op && op == mpio_pkg::OP_PD_READ |=> acc_out == $past(pd_sync) && acc_load)
		else $error("pulldown read wrong");
	AST_MISC_READ: assert property (@(posedge clk) disable iff (reset)
		ce && is_op && op == mpio_pkg::OP_READ_MISC |=> acc_out[0] == $past(low_sync[0])
		&& acc_out[3] == $past(irq_clean))
		else $error("misc read wrong");
	AST_READ_KEEPS: assert property (@(posedge clk) disable iff (reset)
		ce && is_op && next_load && !clr_sync[1] |=> $stable(select_line_bank_out)
		&& $stable(wide_nibble_bank))
		else $error("read changed latch");
	AST_SLOW_AFTER_CLEAR: assert property (@(posedge clk) disable iff (reset)
		clr_sync[1] |=> slow_clk)
		else $error("clock not slow after clear");
	AST_WIDE_WRITE: assert property (@(posedge clk) disable iff (reset)
		ce && is_op && op == mpio_pkg::OP_ACC_TO_WIDE && !clr_sync[1]
		|=> grp(wide_nibble_bank, $past(word_pick_field)) == $past(acc_in))
		else $error("wide write lost");
	COV_FETCH: cover property (@(posedge clk) fetch_start);
	COV_TRI: cover property (@(posedge clk) is_op && op == mpio_pkg::OP_TRI_WRITE ##1 is_op
		&& op == mpio_pkg::OP_TRI_READ);
	COV_TEST: cover property (@(posedge clk) is_op && op == mpio_pkg::OP_BANK_TEST);
	COV_CLEAR: cover property (@(posedge clk) clr_sync[1] ##1 !clr_sync[1]);
endmodule

// ===== include/mpio_pkg.sv
package mpio_pkg;
	localparam int NIB = 4;
	localparam int BANK_PINS = 16;
	localparam int BIDIR_FIRST = 10;
	localparam int WIDE_GROUPS = 4;
	localparam int CLK_MHZ = 100;
	// Instruction cycle and reset timing
	localparam int INSTR_CYCLE_NS = 80;
	localparam int INSTR_CYCLES = (INSTR_CYCLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CLEAR_HOLD_INSTR = 2;
	localparam int CLEAR_RELEASE_INSTR = 2;
	localparam int FILTER_INSTR = 2;
	localparam int SLOW_DIV = 8;
	localparam int FAST_DIV = 4;
	localparam logic [3:0] RESET_NIB = 4'h0;
	localparam logic [15:0] RESET_BANK = 16'h0000;
	localparam logic [12:0] START_ADDR = 13'h0000;
	// Operation codes
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_READ_ANALOG = 4'h1;
	localparam logic [3:0] OP_READ_MISC = 4'h2;
	localparam logic [3:0] OP_TRI_WRITE = 4'h3;
	localparam logic [3:0] OP_TRI_READ = 4'h4;
	localparam logic [3:0] OP_PD_WRITE = 4'h5;
	localparam logic [3:0] OP_PD_READ = 4'h6;
	localparam logic [3:0] OP_ACC_TO_WIDE = 4'h7;
	localparam logic [3:0] OP_WIDE_LOAD = 4'h8;
	localparam logic [3:0] OP_WIDE_STORE = 4'h9;
	localparam logic [3:0] OP_BANK_SET = 4'hA;
	localparam logic [3:0] OP_BANK_RESET = 4'hB;
	localparam logic [3:0] OP_BANK_TEST = 4'hC;
	localparam logic [3:0] OP_TONE_GP = 4'hD;
	localparam logic [3:0] OP_CLK_SPEED = 4'hE;
	localparam logic [3:0] OP_DIR = 4'hF;
endpackage

// ===== tb/mpio_pins_model.sv
module mpio_pins_model
(
	input wire logic [3:0] tri_out,
	input wire logic [3:0] tri_oe,
	input wire logic [3:0] pd_out,
	input wire logic [3:0] pd_oe,
	input wire logic [15:0] bank_out,
	input wire logic [15:0] bank_oe,
	input wire logic [3:0] ext_tri,
	input wire logic [3:0] ext_pd,
	input wire logic [15:0] ext_bank,
	output logic [3:0] tri_in,
	output logic [3:0] pd_in,
	output logic [15:0] bank_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wire level: tristate and bank drivers win where enabled, else the external circuit; pulldown pins OR the two
	always_comb
	begin
		// Released pins show the key level; pulled-down pins need a low latch
		tri_in = (tri_oe & tri_out) | (~tri_oe & ext_tri);
		pd_in = (pd_oe & pd_out) | ext_pd;
		bank_in = (bank_oe & bank_out) | (~bank_oe & ext_bank);
	end
endmodule

// ===== tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clear_in_pin = 1'b0;
	logic [3:0] op = 4'h0;
	logic op_valid = 1'b0;
	logic [3:0] acc_in = 4'h0;
	logic [3:0] temp_in = 4'h0;
	logic [3:0] file_f = 4'h0;
	logic [3:0] word_f = 4'h0;
	logic tone_src = 1'b0;
	logic [3:0] keys = 4'h0;
	logic low_in = 1'b0;
	logic tmr_in = 1'b0;
	logic wake_in = 1'b0;
	logic irq_in = 1'b0;
	logic [3:0] ext_tri = 4'h0;
	logic [3:0] ext_pd = 4'h0;
	logic [15:0] ext_bank = 16'h0000;
	logic [3:0] tri_in, tri_out, tri_oe, pd_in, pd_out, pd_oe, acc_out, temp_out;
	logic [15:0] bank_in, bank_out, bank_oe, wide;
	logic acc_load, test_flag, tone_out, mirror, in_reset, fetch_start;
	logic [7:0] ram_ptr;
	logic [12:0] fetch_addr;
	int n_mismatch = 0;
	int n_checks = 0;
	always #5 clk = ~clk;
	mpio_pins_model pins_u (.tri_out(tri_out), .tri_oe(tri_oe), .pd_out(pd_out),
		.pd_oe(pd_oe), .bank_out(bank_out), .bank_oe(bank_oe), .ext_tri(ext_tri),
		.ext_pd(ext_pd), .ext_bank(ext_bank), .tri_in(tri_in), .pd_in(pd_in),
		.bank_in(bank_in));
	mpio_port dut_u (.clk(clk), .reset(reset), .ce(1'b1), .clear_in_pin(clear_in_pin),
		.op(op), .op_valid(op_valid), .acc_in(acc_in), .temp_nibble_in(temp_in),
		.file_pick_field(file_f), .word_pick_field(word_f), .tone_src(tone_src),
		.analog_key_in(keys), .buffered_low_in(low_in), .timer_clock_in(tmr_in),
		.debounced_wake_in(wake_in), .debounced_irq_in(irq_in),
		.tristate_nibble_in(tri_in), .pulldown_nibble_one_in(pd_in),
		.select_line_bank_in(bank_in), .tristate_nibble_out(tri_out),
		.tristate_nibble_oe(tri_oe), .pulldown_nibble_one_out(pd_out),
		.pulldown_nibble_one_oe(pd_oe), .select_line_bank_out(bank_out),
		.select_line_bank_oe(bank_oe), .wide_nibble_bank(wide), .acc_out(acc_out),
		.temp_nibble_out(temp_out), .acc_load(acc_load), .bank_test_flag(test_flag),
		.tone_out(tone_out), .sysclk_mirror(mirror), .ram_pointer(ram_ptr),
		.in_reset(in_reset), .fetch_start(fetch_start), .fetch_addr(fetch_addr));
	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic do_op(input logic [3:0] o, input logic [3:0] a, input logic [3:0] w);
		@(posedge clk);
		op <= o;
		acc_in <= a;
		word_f <= w;
		op_valid <= 1'b1;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic half_period(output int n);
		logic v;
		int k;
		k = 0;
		v = mirror;
		while (mirror === v && k < 200) begin @(posedge clk); k++; end
		v = mirror;
		n = 0;
		while (mirror === v && n < 200) begin @(posedge clk); n++; end
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		int k;
		chk(bank_oe, 16'h03FF);
		chk({tri_oe, pd_oe}, 8'h00);
		chk(bank_out, 16'h0000);
		k = 0;
		while (fetch_start !== 1'b1 && k < 300) begin @(posedge clk); #1; k++; end
		chk(fetch_start, 1'b1);
		chk(fetch_addr, 13'h0000);
	endtask
	task automatic t_tristate;
		do_op(mpio_pkg::OP_TRI_WRITE, 4'h5, 4'h0);
		chk({tri_out, tri_oe}, 8'h5F);
		ext_tri <= 4'h9;
		do_op(mpio_pkg::OP_TRI_READ, 4'h0, 4'h0);
		wait_cyc(5);
		do_op(mpio_pkg::OP_TRI_READ, 4'h0, 4'h0);
		chk({acc_load, acc_out}, 5'h19);
		chk(tri_oe, 4'h0);
		chk(tri_out, 4'h5);
	endtask
	task automatic t_pulldown;
		do_op(mpio_pkg::OP_PD_WRITE, 4'hA, 4'h0);
		chk({pd_out, pd_in}, 8'hAA);
		do_op(mpio_pkg::OP_PD_WRITE, 4'h0, 4'h0);
		do_op(mpio_pkg::OP_DIR, 4'h0, 4'h0);
		ext_pd <= 4'h6;
		wait_cyc(5);
		do_op(mpio_pkg::OP_PD_READ, 4'h0, 4'h0);
		chk({acc_load, acc_out}, 5'h16);
		chk(pd_out, 4'h0);
	endtask
	task automatic t_inputs;
		keys <= 4'hC;
		low_in <= 1'b1;
		wake_in <= 1'b1;
		wait_cyc(100);
		do_op(mpio_pkg::OP_READ_ANALOG, 4'h0, 4'h0);
		chk(acc_out, 4'hC);
		do_op(mpio_pkg::OP_READ_MISC, 4'h0, 4'h0);
		chk(acc_out, 4'h1);
		low_in <= 1'b0;
		tmr_in <= 1'b1;
		irq_in <= 1'b1;
		wait_cyc(250);
		do_op(mpio_pkg::OP_READ_MISC, 4'h0, 4'h0);
		chk(acc_out, 4'hE);
	endtask
	task automatic t_bank;
		for (int i = 0; i < 16; i++)
		begin
			do_op(mpio_pkg::OP_BANK_SET, 4'h0, i[3:0]);
			chk(bank_out[i], 1'b1);
		end
		for (int i = 0; i < 16; i++)
			do_op(mpio_pkg::OP_BANK_RESET, 4'h0, i[3:0]);
		chk(bank_out, 16'h0000);
		ext_bank <= 16'h5400;
		wait_cyc(5);
		for (int i = 10; i < 16; i++)
		begin
			do_op(mpio_pkg::OP_BANK_TEST, 4'h0, i[3:0]);
			chk(test_flag, ext_bank[i]);
		end
		chk(bank_out, 16'h0000);
	endtask
	task automatic t_wide;
		for (int g = 0; g < 4; g++)
			do_op(mpio_pkg::OP_ACC_TO_WIDE, 4'(g + 5), g[3:0]);
		chk(wide, 16'h8765);
		temp_in <= 4'hC;
		do_op(mpio_pkg::OP_WIDE_STORE, 4'h3, 4'h0);
		chk(wide, 16'h87C3);
		do_op(mpio_pkg::OP_WIDE_LOAD, 4'h0, 4'h0);
		chk({temp_out, acc_out}, 8'hC3);
	endtask
	task automatic t_misc;
		int n;
		do_op(mpio_pkg::OP_TONE_GP, 4'h3, 4'h0);
		wait_cyc(1);
		chk(tone_out, 1'b1);
		do_op(mpio_pkg::OP_TONE_GP, 4'h2, 4'h0);
		wait_cyc(1);
		chk(tone_out, 1'b0);
		tone_src <= 1'b1;
		do_op(mpio_pkg::OP_TONE_GP, 4'h0, 4'h0);
		wait_cyc(3);
		chk(tone_out, 1'b1);
		file_f <= 4'h9;
		word_f <= 4'h3;
		wait_cyc(3);
		chk(ram_ptr, 8'h93);
		half_period(n);
		chk(16'(n), 16'(mpio_pkg::INSTR_CYCLES * mpio_pkg::SLOW_DIV / 2));
		do_op(mpio_pkg::OP_CLK_SPEED, 4'h0, 4'h0);
		half_period(n);
		half_period(n);
		chk(16'(n), 16'(mpio_pkg::INSTR_CYCLES * mpio_pkg::FAST_DIV / 2));
	endtask
	task automatic t_clear;
		int k;
		int n;
		do_op(mpio_pkg::OP_DIR, 4'h1, 4'hA);
		chk(bank_oe, 16'h07FF);
		do_op(mpio_pkg::OP_PD_WRITE, 4'h5, 4'h0);
		clear_in_pin <= 1'b1;
		wait_cyc(200);
		chk(in_reset, 1'b1);
		clear_in_pin <= 1'b0;
		wait_cyc(3);
		chk(bank_oe, 16'h03FF);
		chk({pd_out, pd_oe}, 8'h00);
		k = 0;
		while (fetch_start !== 1'b1 && k < 300)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(fetch_start, 1'b1);
		chk(fetch_addr, 13'h0000);
		half_period(n);
		chk(16'(n), 16'(mpio_pkg::INSTR_CYCLES * mpio_pkg::SLOW_DIV / 2));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		#1;
		t_reset();
		t_tristate();
		t_pulldown();
		t_inputs();
		t_bank();
		t_wide();
		t_misc();
		t_clear();
		summarize();
	end
	initial
	begin
		#200000;
		n_mismatch++;
		summarize();
	end
endmodule
